/* File: ssc_defines.svh */
// register map, command codes, field values and timing for station signaling control
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH
`define SSC_A_CMD 8'h00
`define SSC_A_RESULT 8'h04
`define SSC_A_FLASH 8'h08
`define SSC_A_DISC 8'h0c
`define SSC_A_PHONE 8'h10
`define SSC_A_PSTATE 8'h14
`define SSC_A_POL 8'h18
`define SSC_A_VMWI 8'h1c
`define SSC_A_UNK 8'h20
`define SSC_A_VIEW 8'h24
`define SSC_A_PROFILE 8'h28
`define SSC_A_DTMF 8'h2c
`define SSC_OP_FLASH_TIM 8'h01
`define SSC_OP_POL_REV 8'h02
`define SSC_OP_POL_NORM 8'h03
`define SSC_OP_WAIT_TONE 8'h04
`define SSC_OP_CID_DT 8'h05
`define SSC_OP_CID_NAME 8'h06
`define SSC_OP_CID_CUSTOM 8'h07
`define SSC_OP_CID_APPEND 8'h08
`define SSC_OP_VMWI 8'h09
`define SSC_OP_METER 8'h0a
`define SSC_PS_IDLE 2'h0
`define SSC_PS_RING 2'h1
`define SSC_PS_CONNECT 2'h2
`define SSC_RES_OK 2'h1
`define SSC_RES_REFUSED 2'h2
`define SSC_RES_UNKNOWN 2'h3
`define SSC_FMIN_RST 8'h23
`define SSC_FMAX_RST 8'h64
`define SSC_CLK_NS 4
`define SSC_TICK_NS 10000000
`define SSC_TICK_CYCLES (`SSC_TICK_NS / `SSC_CLK_NS)
`define SSC_TICK_MS 10
`define SSC_BURST_SHORT_MS 100
`define SSC_BURST_LONG_MS 300
`define SSC_METER_MS 100
`define SSC_CID_MAX 8'h80
`define SSC_NAME_MAX 8'h1c
`define SSC_MDMF 8'h80
`define SSC_PT_DT 8'h01
`define SSC_PT_NUM 8'h02
`define SSC_PT_NAME 8'h07
`define SSC_SEP 8'h2f
`define SSC_ACT_ON 8'h46
`define SSC_ACT_OFF 8'h4e
`define SSC_OPT_E 8'h45
`endif

/* File: ssc_pkg.sv */
// types for station signaling control
`default_nettype none
package ssc_pkg;
  typedef enum logic {TN_IDLE, TN_RUN} ssc_tone_e;
  typedef enum logic {CX_IDLE, CX_SEND} ssc_cid_e;
endpackage : ssc_pkg
`default_nettype wire

/* File: ssc_station_ctrl.sv */
// station port signaling control: ahb-lite registers, hook flash, polarity, tones, caller id, metering
// Functional notes
// - report each flash on phone ports
// - flash only reports, changes nothing else (its on-hook edge still returns polarity to normal)
// - flash window set per port, 10 ms units
// - short on-hook ignored, long means disconnect
// - flash timing applies to phone ports only
// - flash window readable for nonvolatile storage
// - reverse and restore polarity per port
// - refuse reversal when idle or ringing
// - polarity normal on disconnect or on-hook
// - waiting tone only in connect state
// - five waiting tone patterns
// - E suffix enables digit detection
// - send caller data in first ring gap
// - date, time, separator then number
// - name up to 28 characters
// - custom octets, appended up to 128
// - caller data framed as multiple message
// - visual indicator only on-hook idle
// - one 100 ms meter pulse, profile matched
// - echo unknown commands with marker
//
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defines.svh"
module ssc_station_ctrl #(
  parameter int NPORTS = 8,
  parameter int TICK_CYCLES = `SSC_TICK_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // station pins
  input wire logic [NPORTS-1:0] hook_off,
  input wire logic [NPORTS-1:0] ring_on,
  output logic [NPORTS-1:0] pol_rev,
  output logic [NPORTS-1:0] vmwi_on,
  output logic [NPORTS-1:0] dtmf_en,
  // tone and meter engines
  output logic tone_on,
  output logic [7:0] tone_port,
  output logic meter_12k,
  output logic meter_16k,
  output logic [7:0] meter_port,
  // caller data stream
  input wire logic cid_ready,
  output logic cid_valid,
  output logic [7:0] cid_data,
  output logic [7:0] cid_port
);
  localparam logic [7:0] T_SHORT = 8'(`SSC_BURST_SHORT_MS / `SSC_TICK_MS);
  localparam logic [7:0] T_LONG = 8'(`SSC_BURST_LONG_MS / `SSC_TICK_MS);
  localparam logic [7:0] T_METER = 8'(`SSC_METER_MS / `SSC_TICK_MS);

  logic [31:0] tick_q, tick_d, hrdata_q, hrdata_d, unk_q, unk_d;
  logic ph_wr_q, ph_wr_d, tick, rdy_q;
  logic [7:0] ph_addr_q, ph_addr_d;
  logic [NPORTS-1:0] hook_m_q, hook_s_q, hook_p_q, ring_m_q, ring_s_q, ring_p_q;
  logic [NPORTS-1:0] flash_q, flash_d, disc_q, disc_d, phone_q, phone_d, pol_q, pol_d;
  logic [NPORTS-1:0] vmwi_q, vmwi_d, dtmf_q, dtmf_d, polo_q, polo_d;
  logic [7:0] cnt_q [NPORTS];
  logic [7:0] cnt_d [NPORTS];
  logic [7:0] fmin_q [NPORTS];
  logic [7:0] fmin_d [NPORTS];
  logic [7:0] fmax_q [NPORTS];
  logic [7:0] fmax_d [NPORTS];
  logic [1:0] pstate_q [NPORTS];
  logic [1:0] pstate_d [NPORTS];
  logic [1:0] prof_q [NPORTS];
  logic [1:0] prof_d [NPORTS];
  logic [17:0] result_q, result_d;
  logic [7:0] view_q, view_d;
  // tone sequencer
  ssc_pkg::ssc_tone_e tn_q, tn_d;
  logic [2:0] tn_pat_q, tn_pat_d, tn_seg_q, tn_seg_d;
  logic [7:0] tn_cnt_q, tn_cnt_d, tn_port_q, tn_port_d;
  logic tone_q, tone_d, tn_done;
  // meter pulse
  logic [7:0] mt_cnt_q, mt_cnt_d, mt_port_q, mt_port_d;
  logic [1:0] mt_fmt_q, mt_fmt_d;
  logic m12_q, m12_d, m16_q, m16_d;
  // caller data buffer and sender
  logic [7:0] buf_q [128];
  logic [7:0] buf_d [128];
  logic [7:0] wr_q, wr_d, rd_q, rd_d, plen_q, plen_d, name_q, name_d, own_q, own_d;
  logic std_q, std_d, staged_q, staged_d, cv_q, cv_d;
  logic [7:0] cdat_q, cdat_d;
  ssc_pkg::ssc_cid_e cx_q, cx_d;
  // command fields
  logic cmd_wr;
  logic [7:0] op, pt, ca, cb;
  int p;

  function automatic logic [7:0] seg_len(input logic [2:0] pat, input logic [2:0] s);
    seg_len = 8'h00;
    case (pat)
      3'h0: if (s == 3'h0) seg_len = T_LONG;
      3'h1: if (s <= 3'h2) seg_len = T_SHORT;
      3'h2: if (s <= 3'h4) seg_len = s[0] ? T_SHORT : T_LONG;
      3'h3: if (s <= 3'h4) seg_len = (s == 3'h2) ? T_LONG : T_SHORT;
      default: seg_len = 8'h00;
    endcase
  endfunction : seg_len

  // command decode straight from the data phase of a cmd write
  assign cmd_wr = ph_wr_q && (ph_addr_q == `SSC_A_CMD);
  assign op = hwdata[7:0];
  assign pt = hwdata[15:8];
  assign ca = hwdata[23:16];
  assign cb = hwdata[31:24];
  assign p = (int'(pt) < NPORTS) ? int'(pt) : 0;
  assign tick = (tick_q == 32'(TICK_CYCLES - 1));

  // next state for everything; bus effects first so hardware sets win over clears
  always_comb begin
    logic [1:0] res;
    logic cid_ok;
    res = `SSC_RES_OK;
    cid_ok = 1'b0;
    tick_d = tick ? 32'h0 : tick_q + 32'h1;
    ph_wr_d = hsel && htrans[1] && hready && hwrite && (hsize == 3'h2);
    ph_addr_d = haddr[7:0];
    hrdata_d = 32'h0;
    unk_d = unk_q;
    flash_d = flash_q;
    disc_d = disc_q;
    phone_d = phone_q;
    pol_d = pol_q;
    vmwi_d = vmwi_q;
    dtmf_d = dtmf_q;
    cnt_d = cnt_q;
    fmin_d = fmin_q;
    fmax_d = fmax_q;
    pstate_d = pstate_q;
    prof_d = prof_q;
    result_d = result_q;
    view_d = view_q;
    tn_d = tn_q;
    tn_pat_d = tn_pat_q;
    tn_seg_d = tn_seg_q;
    tn_cnt_d = tn_cnt_q;
    tn_port_d = tn_port_q;
    tn_done = 1'b0;
    mt_cnt_d = mt_cnt_q;
    mt_port_d = mt_port_q;
    mt_fmt_d = mt_fmt_q;
    buf_d = buf_q;
    wr_d = wr_q;
    rd_d = rd_q;
    plen_d = plen_q;
    name_d = name_q;
    own_d = own_q;
    std_d = std_q;
    staged_d = staged_q;
    cv_d = cv_q;
    cdat_d = cdat_q;
    cx_d = cx_q;
    // register writes; flag registers are write-one-to-clear
    if (ph_wr_q) begin
      case (ph_addr_q)
        `SSC_A_FLASH: flash_d = flash_q & ~hwdata[NPORTS-1:0];
        `SSC_A_DISC: disc_d = disc_q & ~hwdata[NPORTS-1:0];
        `SSC_A_PHONE: phone_d = hwdata[NPORTS-1:0];
        `SSC_A_VIEW: view_d = hwdata[7:0];
        `SSC_A_PSTATE: for (int i = 0; i < NPORTS; i++) begin
          pstate_d[i] = hwdata[2*i +: 2];
          if (hwdata[2*i +: 2] == `SSC_PS_IDLE) pol_d[i] = 1'b0;
        end
        `SSC_A_PROFILE: for (int i = 0; i < NPORTS; i++) prof_d[i] = hwdata[2*i +: 2];
        default: ;
      endcase
    end
    // command interpreter
    if (cmd_wr) begin
      if (int'(pt) >= NPORTS) res = `SSC_RES_UNKNOWN;
      else case (op)
        `SSC_OP_FLASH_TIM: begin
          fmin_d[p] = ca;
          fmax_d[p] = cb;
        end
        `SSC_OP_POL_REV: begin
          if (pstate_q[p] == `SSC_PS_IDLE || pstate_q[p] == `SSC_PS_RING) res = `SSC_RES_REFUSED;
          else pol_d[p] = 1'b1;
        end
        `SSC_OP_POL_NORM: pol_d[p] = 1'b0;
        `SSC_OP_WAIT_TONE: begin
          if (ca > 8'h04) res = `SSC_RES_UNKNOWN;
          else if (pstate_q[p] != `SSC_PS_CONNECT || tn_q != ssc_pkg::TN_IDLE) res = `SSC_RES_REFUSED;
          else begin
            dtmf_d[p] = (cb == `SSC_OPT_E);
            tn_pat_d = ca[2:0];
            tn_seg_d = 3'h0;
            tn_port_d = pt;
            tn_cnt_d = seg_len(ca[2:0], 3'h0);
            if (tn_cnt_d == 8'h00) tn_done = 1'b1;
            else tn_d = ssc_pkg::TN_RUN;
          end
        end
        `SSC_OP_CID_DT, `SSC_OP_CID_NAME, `SSC_OP_CID_CUSTOM, `SSC_OP_CID_APPEND: begin
          cid_ok = (cx_q == ssc_pkg::CX_IDLE);
          if (cb[0]) begin
            if (op == `SSC_OP_CID_DT) begin
              buf_d[0] = `SSC_MDMF;
              buf_d[1] = 8'h02;
              buf_d[2] = `SSC_PT_DT;
              buf_d[3] = 8'h00;
              plen_d = 8'h03;
              wr_d = 8'h04;
            end else if (op == `SSC_OP_CID_CUSTOM) begin
              wr_d = 8'h00;
            end
            if (op == `SSC_OP_CID_DT || op == `SSC_OP_CID_CUSTOM) begin
              std_d = (op == `SSC_OP_CID_DT);
              own_d = pt;
              staged_d = cid_ok;
            end
          end
          if (op == `SSC_OP_CID_NAME || op == `SSC_OP_CID_APPEND)
            cid_ok = cid_ok && staged_q && own_q == pt && (std_q == (op == `SSC_OP_CID_NAME));
          if (op == `SSC_OP_CID_NAME && cb[0] && cid_ok) begin
            name_d = 8'h00;
            if (wr_d > `SSC_CID_MAX - 8'h03) cid_ok = 1'b0;
            else begin
              buf_d[wr_d[6:0]] = `SSC_PT_NAME;
              buf_d[wr_d[6:0] + 7'h1] = 8'h00;
              plen_d = wr_d + 8'h01;
              buf_d[1] = buf_d[1] + 8'h02;
              wr_d = wr_d + 8'h02;
            end
          end
          if (op == `SSC_OP_CID_NAME && name_d >= `SSC_NAME_MAX) cid_ok = 1'b0;
          if (std_d && op == `SSC_OP_CID_DT && ca == `SSC_SEP && cid_ok) begin
            // the two-byte number header must still fit, or the index wraps
            if (wr_d > `SSC_CID_MAX - 8'h02) cid_ok = 1'b0;
            else begin
              buf_d[wr_d[6:0]] = `SSC_PT_NUM;
              buf_d[wr_d[6:0] + 7'h1] = 8'h00;
              plen_d = wr_d + 8'h01;
              buf_d[1] = buf_d[1] + 8'h02;
              wr_d = wr_d + 8'h02;
            end
          end else if (cid_ok && wr_d < `SSC_CID_MAX) begin
            buf_d[wr_d[6:0]] = ca;
            if (std_d) begin
              buf_d[plen_d[6:0]] = buf_d[plen_d[6:0]] + 8'h01;
              buf_d[1] = buf_d[1] + 8'h01;
            end
            if (op == `SSC_OP_CID_NAME) name_d = name_d + 8'h01;
            wr_d = wr_d + 8'h01;
          end else cid_ok = 1'b0;
          if (!cid_ok) begin
            res = `SSC_RES_REFUSED;
            buf_d = buf_q;
            wr_d = wr_q;
            plen_d = plen_q;
            name_d = name_q;
            std_d = std_q;
            own_d = own_q;
            staged_d = staged_q;
          end
        end
        `SSC_OP_VMWI: begin
          if (ca != `SSC_ACT_ON && ca != `SSC_ACT_OFF) res = `SSC_RES_UNKNOWN;
          else if (hook_s_q[p] || pstate_q[p] != `SSC_PS_IDLE) res = `SSC_RES_REFUSED;
          else vmwi_d[p] = (ca == `SSC_ACT_ON);
        end
        `SSC_OP_METER: begin
          if (ca > 8'h02) res = `SSC_RES_UNKNOWN;
          else if (prof_q[p] != ca[1:0] || mt_cnt_q != 8'h00) res = `SSC_RES_REFUSED;
          else begin
            mt_cnt_d = T_METER;
            mt_fmt_d = ca[1:0];
            mt_port_d = pt;
          end
        end
        default: res = `SSC_RES_UNKNOWN;
      endcase
      if (res == `SSC_RES_UNKNOWN) unk_d = hwdata;
      result_d = {res, pt, op};
    end
    // hook timing per port; a flash only raises its report bit
    for (int i = 0; i < NPORTS; i++) begin
      if (hook_s_q[i]) cnt_d[i] = 8'h00;
      else if (tick && cnt_q[i] != 8'hff) cnt_d[i] = cnt_q[i] + 8'h01;
      if (hook_s_q[i] && !hook_p_q[i] && phone_q[i]) begin
        if (cnt_q[i] > fmax_q[i]) disc_d[i] = 1'b1;
        else if (cnt_q[i] >= fmin_q[i]) flash_d[i] = 1'b1;
      end
      if (!hook_s_q[i] && hook_p_q[i]) pol_d[i] = 1'b0;
    end
    // tone pattern stepping in 10 ms ticks
    if (tn_q == ssc_pkg::TN_RUN && tick) begin
      if (tn_cnt_q > 8'h01) tn_cnt_d = tn_cnt_q - 8'h01;
      else begin
        tn_seg_d = tn_seg_q + 3'h1;
        tn_cnt_d = seg_len(tn_pat_q, tn_seg_d);
        if (tn_cnt_d == 8'h00) begin
          tn_d = ssc_pkg::TN_IDLE;
          tn_done = 1'b1;
        end
      end
    end
    tone_d = (tn_d == ssc_pkg::TN_RUN) && !tn_seg_d[0];
    // meter pulse, reversal format flips the line polarity
    if (tick && mt_cnt_q != 8'h00) mt_cnt_d = mt_cnt_q - 8'h01;
    m12_d = (mt_cnt_d != 8'h00) && mt_fmt_d == 2'h1;
    m16_d = (mt_cnt_d != 8'h00) && mt_fmt_d == 2'h2;
    polo_d = pol_d;
    if (mt_cnt_d != 8'h00 && mt_fmt_d == 2'h0 && int'(mt_port_d) < NPORTS)
      polo_d[mt_port_d[$clog2(NPORTS)-1:0]] = !pol_d[mt_port_d[$clog2(NPORTS)-1:0]];
    // caller data goes out in the first ring gap or after the waiting tone
    if (cx_q == ssc_pkg::CX_IDLE && staged_q && int'(own_q) < NPORTS) begin
      if ((!ring_s_q[own_q[$clog2(NPORTS)-1:0]] && ring_p_q[own_q[$clog2(NPORTS)-1:0]])
          || (tn_done && tn_port_d == own_q)) begin
        cx_d = ssc_pkg::CX_SEND;
        rd_d = 8'h00;
      end
    end else if (cx_q == ssc_pkg::CX_SEND && (!cv_q || cid_ready)) begin
      if (rd_q < wr_q) begin
        cv_d = 1'b1;
        cdat_d = buf_q[rd_q[6:0]];
        rd_d = rd_q + 8'h01;
      end else begin
        cv_d = 1'b0;
        cx_d = ssc_pkg::CX_IDLE;
        staged_d = 1'b0;
      end
    end
    // read data prepared in the address phase; unmapped reads return zero
    if (hsel && htrans[1] && hready && !hwrite) begin
      case (haddr[7:0])
        `SSC_A_RESULT: hrdata_d = 32'(result_q);
        `SSC_A_FLASH: hrdata_d = 32'(flash_q);
        `SSC_A_DISC: hrdata_d = 32'(disc_q);
        `SSC_A_PHONE: hrdata_d = 32'(phone_q);
        `SSC_A_POL: hrdata_d = 32'(pol_q);
        `SSC_A_VMWI: hrdata_d = 32'(vmwi_q);
        `SSC_A_DTMF: hrdata_d = 32'(dtmf_q);
        `SSC_A_UNK: hrdata_d = unk_q;
        `SSC_A_VIEW: if (int'(view_q) < NPORTS)
          hrdata_d = {16'h0, fmax_q[view_q[$clog2(NPORTS)-1:0]], fmin_q[view_q[$clog2(NPORTS)-1:0]]};
        `SSC_A_PSTATE: for (int i = 0; i < NPORTS; i++) hrdata_d[2*i +: 2] = pstate_q[i];
        `SSC_A_PROFILE: for (int i = 0; i < NPORTS; i++) hrdata_d[2*i +: 2] = prof_q[i];
        default: hrdata_d = 32'h0;
      endcase
    end
  end

  // registers; pins pass two flops before use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_q <= 32'h0;
      {hook_m_q, hook_s_q, hook_p_q, ring_m_q, ring_s_q, ring_p_q} <= '0;
      {flash_q, disc_q, phone_q, pol_q, vmwi_q, dtmf_q, polo_q} <= '0;
      ph_wr_q <= 1'b0;
      rdy_q <= 1'b0;
      ph_addr_q <= 8'h00;
      hrdata_q <= 32'h0;
      unk_q <= 32'h0;
      result_q <= 18'h0;
      view_q <= 8'h00;
      for (int i = 0; i < NPORTS; i++) begin
        cnt_q[i] <= 8'h00;
        fmin_q[i] <= `SSC_FMIN_RST;
        fmax_q[i] <= `SSC_FMAX_RST;
        pstate_q[i] <= `SSC_PS_IDLE;
        prof_q[i] <= 2'h0;
      end
      tn_q <= ssc_pkg::TN_IDLE;
      {tn_pat_q, tn_seg_q} <= 6'h0;
      {tn_cnt_q, tn_port_q, mt_cnt_q, mt_port_q} <= 32'h0;
      {mt_fmt_q, m12_q, m16_q, tone_q} <= 5'h0;
      for (int i = 0; i < 128; i++) buf_q[i] <= 8'h00;
      {wr_q, rd_q, plen_q, name_q, own_q, cdat_q} <= 48'h0;
      {std_q, staged_q, cv_q} <= 3'h0;
      cx_q <= ssc_pkg::CX_IDLE;
    end else begin
      tick_q <= tick_d;
      hook_m_q <= hook_off;
      hook_s_q <= hook_m_q;
      hook_p_q <= hook_s_q;
      ring_m_q <= ring_on;
      ring_s_q <= ring_m_q;
      ring_p_q <= ring_s_q;
      {flash_q, disc_q, phone_q, pol_q, vmwi_q, dtmf_q, polo_q} <=
        {flash_d, disc_d, phone_d, pol_d, vmwi_d, dtmf_d, polo_d};
      ph_wr_q <= ph_wr_d;
      rdy_q <= 1'b1;
      ph_addr_q <= ph_addr_d;
      hrdata_q <= hrdata_d;
      unk_q <= unk_d;
      result_q <= result_d;
      view_q <= view_d;
      cnt_q <= cnt_d;
      fmin_q <= fmin_d;
      fmax_q <= fmax_d;
      pstate_q <= pstate_d;
      prof_q <= prof_d;
      tn_q <= tn_d;
      {tn_pat_q, tn_seg_q} <= {tn_pat_d, tn_seg_d};
      {tn_cnt_q, tn_port_q, mt_cnt_q, mt_port_q} <= {tn_cnt_d, tn_port_d, mt_cnt_d, mt_port_d};
      {mt_fmt_q, m12_q, m16_q, tone_q} <= {mt_fmt_d, m12_d, m16_d, tone_d};
      buf_q <= buf_d;
      {wr_q, rd_q, plen_q, name_q, own_q, cdat_q} <= {wr_d, rd_d, plen_d, name_d, own_d, cdat_d};
      {std_q, staged_q, cv_q} <= {std_d, staged_d, cv_d};
      cx_q <= cx_d;
    end
  end

  // every output but hresp is a flop; zero wait states, always okay
  assign hrdata = hrdata_q;
  assign hreadyout = rdy_q; // low through reset, high from the first edge after
  assign hresp = 1'b0;
  assign pol_rev = polo_q;
  assign vmwi_on = vmwi_q;
  assign dtmf_en = dtmf_q;
  assign tone_on = tone_q;
  assign tone_port = tn_port_q;
  assign meter_12k = m12_q;
  assign meter_16k = m16_q;
  assign meter_port = mt_port_q;
  assign cid_valid = cv_q;
  assign cid_data = cdat_q;
  assign cid_port = own_q;

  // checks on port 0 and the shared engines
  logic hedge0;
  logic [31:0] mt_len_q;
  assign hedge0 = hook_s_q[0] && !hook_p_q[0];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) mt_len_q <= 32'h0;
    else mt_len_q <= (mt_cnt_q != 8'h00) ? mt_len_q + 32'h1 : 32'h0;
  end
  default clocking cb_main @(posedge hclk); endclocking
  default disable iff (!hresetn);
  flash_report_a: assert property (hedge0 && phone_q[0] && cnt_q[0] >= fmin_q[0] && cnt_q[0] <= fmax_q[0]
    |=> flash_q[0]) else $error("flash not reported");
  flash_short_a: assert property (hedge0 && !flash_q[0] && !disc_q[0] && cnt_q[0] < fmin_q[0]
    |=> !flash_q[0] && !disc_q[0])
    else $error("short on-hook not ignored");
  flash_long_a: assert property (hedge0 && phone_q[0] && cnt_q[0] > fmax_q[0] |=> disc_q[0])
    else $error("long on-hook not a disconnect");
  flash_phone_a: assert property (hedge0 && !phone_q[0] && !flash_q[0] |=> !flash_q[0])
    else $error("flash on non-phone port");
  flash_quiet_a: assert property (hedge0 && !cmd_wr && !ph_wr_q
    |=> $stable(dtmf_q) && $stable(pol_q[0]) && $stable(pstate_q[0])) else $error("flash changed port state");
  pol_refuse_a: assert property (cmd_wr && op == `SSC_OP_POL_REV && pt == 8'h00 && !pol_q[0]
    && pstate_q[0] == `SSC_PS_IDLE |=> !pol_q[0]) else $error("reversal accepted while idle");
  pol_onhook_a: assert property (!hook_s_q[0] && hook_p_q[0] |=> !pol_q[0])
    else $error("polarity kept after on-hook");
  tone_refuse_a: assert property (cmd_wr && op == `SSC_OP_WAIT_TONE && int'(pt) < NPORTS && ca <= 8'h04
    && pstate_q[p] != `SSC_PS_CONNECT |=> result_q[17:16] == `SSC_RES_REFUSED) else $error("tone outside connect");
  meter_len_a: assert property ($fell(mt_cnt_q != 8'h00) |-> $past(mt_len_q) >= 32'(TICK_CYCLES * 9))
    else $error("meter pulse too short");
  unk_echo_a: assert property (cmd_wr && int'(pt) >= NPORTS |=> unk_q == $past(hwdata)
    && result_q[17:16] == `SSC_RES_UNKNOWN) else $error("unknown command not echoed");
  cid_cap_a: assert property (wr_q <= `SSC_CID_MAX) else $error("caller buffer overrun");
  vmwi_gate_a: assert property (cmd_wr && op == `SSC_OP_VMWI && pt == 8'h00 && hook_s_q[0]
    |=> $stable(vmwi_q[0])) else $error("indicator changed off-hook");
  flash_seen_c: cover property (hedge0 ##1 flash_q[0]);
  tone_run_c: cover property ($rose(tone_q) && tn_pat_q == 3'h2);
  cid_send_c: cover property (cv_q && cid_ready);
endmodule : ssc_station_ctrl
`default_nettype wire

/* File: ssc_station_model.sv */
// station set side model: caller data sink that stalls part of the time
`timescale 1ns/1ps
`default_nettype none
module ssc_station_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // caller data stream
  input wire logic cid_valid,
  input wire logic [7:0] cid_data,
  output logic cid_ready
);
  logic [7:0] rx [0:31];
  int n;
  logic [1:0] ph_q;
  // ready three cycles in four, so the source must hold bytes across stalls
  assign cid_ready = (ph_q != 2'h3);
  // keep the first 32 accepted bytes in arrival order
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 2'h0;
      n <= 0;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (cid_valid && cid_ready && n < 32) begin
        rx[n] <= cid_data;
        n <= n + 1;
      end
    end
  end
endmodule : ssc_station_model
`default_nettype wire

/* File: ssc_station_ctrl_test.sv */
// self-checking bench for station signaling control
`timescale 1ns/1ps
`default_nettype none
module ssc_station_ctrl_test;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, tone_on, meter_12k, meter_16k, cid_ready, cid_valid;
  logic [7:0] hook_off = 8'hf3, ring_on = 8'h00, pol_rev, vmwi_on, dtmf_en;
  logic [7:0] tone_port, meter_port, cid_data, cid_port;
  int n_errors = 0, comparisons = 0, c, i;
  int on_ticks [0:4] = '{30, 20, 90, 50, 0};
  logic [7:0] dt [0:12] = '{8'h30, 8'h34, 8'h30, 8'h33, 8'h30, 8'h32, 8'h30, 8'h31, 8'h2f,
    8'h35, 8'h35, 8'h35, 8'h35};
  assign hready = hreadyout;
  ssc_station_ctrl #(.NPORTS(8), .TICK_CYCLES(4)) ssc_station_ctrl_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .hook_off(hook_off),
    .ring_on(ring_on), .pol_rev(pol_rev), .vmwi_on(vmwi_on), .dtmf_en(dtmf_en), .tone_on(tone_on),
    .tone_port(tone_port), .meter_12k(meter_12k), .meter_16k(meter_16k), .meter_port(meter_port),
    .cid_ready(cid_ready), .cid_valid(cid_valid), .cid_data(cid_data), .cid_port(cid_port));
  ssc_station_model ssc_station_model_i (.hclk(hclk), .hresetn(hresetn), .cid_valid(cid_valid),
    .cid_data(cid_data), .cid_ready(cid_ready));
  // 250 mhz clock
  always #2 hclk = ~hclk;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one single word transfer; the gap before the next one gives the idle cycle
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : bus
  task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(what, r, exp);
  endtask : rd
  task automatic cmd(input logic [31:0] w, input logic [31:0] res);
    bus(32'h0, 1'b1, w);
    rd("result", 32'h4, res);
  endtask : cmd
  // count cycles a gate stays high over a window
  task automatic gate(input int n, input bit meter);
    c = 0;
    repeat (n) begin
      @(posedge hclk);
      if ((meter ? meter_12k : tone_on) === 1'b1) c++;
    end
  endtask : gate
  task automatic onhook(input logic [7:0] m, input int cyc);
    @(posedge hclk) hook_off <= hook_off & ~m;
    repeat (cyc) @(posedge hclk);
    hook_off <= hook_off | m;
    repeat (20) @(posedge hclk);
  endtask : onhook
  task automatic t_flash;
    rd("phone reset", 32'h10, 32'h0);
    bus(32'h24, 1'b1, 32'h0);
    rd("window reset", 32'h24, 32'h00006423);
    bus(32'h10, 1'b1, 32'h1);
    cmd(32'h05020001, 32'h00010001);
    rd("window", 32'h24, 32'h00000502);
    onhook(8'h03, 2);
    rd("short", 32'h08, 32'h0);
    onhook(8'h03, 14);
    rd("flash", 32'h08, 32'h1);
    chk("flash pol", {24'h0, pol_rev}, 32'h0);
    bus(32'h08, 1'b1, 32'h1);
    onhook(8'h03, 40);
    rd("flash long", 32'h08, 32'h0);
    rd("disc", 32'h0c, 32'h1);
  endtask : t_flash
  task automatic t_pol;
    cmd(32'h00000002, 32'h00020002);
    bus(32'h14, 1'b1, 32'h2);
    cmd(32'h00000002, 32'h00010002);
    chk("pol rev", {24'h0, pol_rev}, 32'h1);
    cmd(32'h00000003, 32'h00010003);
    chk("pol norm", {24'h0, pol_rev}, 32'h0);
    cmd(32'h00000002, 32'h00010002);
    onhook(8'h01, 30);
    chk("pol onhook", {24'h0, pol_rev}, 32'h0);
  endtask : t_pol
  task automatic t_tone;
    bus(32'h14, 1'b1, 32'ha);
    cmd(32'h00000204, 32'h00020204);
    for (i = 0; i < 5; i++) begin
      cmd({(i == 0) ? 8'h45 : 8'h00, i[7:0], 16'h0004}, 32'h00010004);
      if (i == 0) chk("dtmf", {24'h0, dtmf_en}, 32'h1);
      chk("tone port", {24'h0, tone_port}, 32'h0);
      gate(500, 1'b0);
      chk("tone len", 32'(c >= on_ticks[i] * 4 - 8 && c <= on_ticks[i] * 4 + 8), 32'h1);
    end
    cmd(32'h00040104, 32'h00010104);
    chk("tone port", {24'h0, tone_port}, 32'h1);
  endtask : t_tone
  task automatic t_misc;
    cmd(32'h1234007f, 32'h0003007f);
    rd("unknown", 32'h20, 32'h1234007f);
    cmd(32'h00000c03, 32'h00030c03);
    rd("unknown port", 32'h20, 32'h00000c03);
    cmd(32'h00460009, 32'h00020009);
    cmd(32'h00460209, 32'h00010209);
    chk("vmwi on", {24'h0, vmwi_on}, 32'h4);
    cmd(32'h004e0209, 32'h00010209);
    chk("vmwi off", {24'h0, vmwi_on}, 32'h0);
    bus(32'h28, 1'b1, 32'h1);
    cmd(32'h0002000a, 32'h0002000a);
    bus(32'h0, 1'b1, 32'h0001000a);
    gate(80, 1'b1);
    chk("meter len", 32'(c >= 36 && c <= 44), 32'h1);
    chk("meter port", {24'h0, meter_port}, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    bus(32'h28, 1'b1, 32'h2);
    cmd(32'h0002000a, 32'h0001000a);
    chk("meter 16k", {31'h0, meter_16k}, 32'h1);
    repeat (50) @(posedge hclk);
    bus(32'h28, 1'b1, 32'h0);
    cmd(32'h0000000a, 32'h0001000a);
    chk("meter rev", {24'h0, pol_rev}, 32'h1);
  endtask : t_misc
  task automatic t_cid;
    bus(32'h14, 1'b1, 32'h40);
    for (i = 0; i < 13; i++) cmd({(i == 0) ? 8'h01 : 8'h00, dt[i], 16'h0305}, 32'h00010305);
    cmd(32'h01410206, 32'h00020206);
    cmd(32'h01410306, 32'h00010306);
    cmd(32'h00420306, 32'h00010306);
    chk("cid port", {24'h0, cid_port}, 32'h3);
    @(posedge hclk) ring_on <= 8'h08;
    repeat (20) @(posedge hclk);
    ring_on <= 8'h00;
    for (i = 0; i < 500 && ssc_station_model_i.n < 22; i++) @(posedge hclk);
    chk("cid idle", {31'h0, cid_valid}, 32'h0);
    chk("cid mdmf", {24'h0, ssc_station_model_i.rx[0]}, 32'h80);
    chk("cid len", {24'h0, ssc_station_model_i.rx[1]}, 32'h14);
    chk("cid dt", {24'h0, ssc_station_model_i.rx[2]}, 32'h01);
    chk("cid dtlen", {24'h0, ssc_station_model_i.rx[3]}, 32'h08);
    chk("cid digit", {24'h0, ssc_station_model_i.rx[4]}, 32'h30);
    chk("cid num", {24'h0, ssc_station_model_i.rx[12]}, 32'h02);
    chk("cid numlen", {24'h0, ssc_station_model_i.rx[13]}, 32'h04);
    chk("cid name", {24'h0, ssc_station_model_i.rx[18]}, 32'h07);
    chk("cid namelen", {24'h0, ssc_station_model_i.rx[19]}, 32'h02);
    chk("cid char", {24'h0, ssc_station_model_i.rx[20]}, 32'h41);
  endtask : t_cid
  task automatic report_and_stop;
    $display("checks %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  // main sequence
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_flash();
    t_pol();
    t_tone();
    t_misc();
    t_cid();
    report_and_stop();
  end
  // watchdog against a hung handshake
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
endmodule : ssc_station_ctrl_test
`default_nettype wire
